// [rtl/sac_pkg.sv]
// Shared offsets, bit positions, reset values and counts of the serial control block.
package sac_pkg;
  // Register byte offsets on the APB side.
  localparam logic [7:0] SAC_OFS_FMT = 8'h00;
  localparam logic [7:0] SAC_OFS_CTL = 8'h04;
  localparam logic [7:0] SAC_OFS_STAT = 8'h08;
  localparam logic [7:0] SAC_OFS_DATA = 8'h0c;
  // Bit positions in serial_format_control.
  localparam int SAC_F_PODD = 0;
  localparam int SAC_F_PAR = 1;
  localparam int SAC_F_ISTOP = 2;
  localparam int SAC_F_MARK = 3;
  localparam int SAC_F_NINE = 4;
  localparam int SAC_F_POL = 5;
  localparam int SAC_F_UNIT = 6;
  localparam int SAC_F_LOOP = 7;
  // Bit positions in serial_irq_tx_rx_control.
  localparam int SAC_C_BRK = 0;
  localparam int SAC_C_STBY = 1;
  localparam int SAC_C_RXON = 2;
  localparam int SAC_C_TXON = 3;
  localparam int SAC_C_IDLE_EN = 4;
  localparam int SAC_C_RXF_EN = 5;
  localparam int SAC_C_TXD_EN = 6;
  localparam int SAC_C_TXE_EN = 7;
  // Bit positions in the status register.
  localparam int SAC_S_TXE = 0;
  localparam int SAC_S_TXD = 1;
  localparam int SAC_S_RXF = 2;
  localparam int SAC_S_IDL = 3;
  localparam int SAC_S_PERR = 4;
  localparam int SAC_S_FERR = 5;
  // Reset values of both control registers.
  localparam logic [7:0] SAC_FMT_RST = 8'h00;
  localparam logic [7:0] SAC_CTL_RST = 8'h00;
  // Frame lengths in bit times, and the single mark bit after a break.
  localparam logic [3:0] SAC_LEN_EIGHT = 4'ha;
  localparam logic [3:0] SAC_LEN_NINE = 4'hb;
  localparam logic [3:0] SAC_LEN_MARK = 4'h1;
  // Clock cycles per bit time.
  localparam int SAC_BIT_CLKS = 16;
  // Receiver states.
  typedef enum logic [1:0] {
    SAC_RX_IDLE = 2'b00,
    SAC_RX_START = 2'b01,
    SAC_RX_DATA = 2'b10,
    SAC_RX_STOP = 2'b11
  } sac_rx_t;
endpackage

// [rtl/sac_tx_if.sv]
// Frame hand-off between the control logic and the transmit shifter.
`timescale 1ns/1ps
`default_nettype none
interface sac_tx_if;
  logic valid; // A frame is offered.
  logic [10:0] frame; // Frame bits, first bit in bit 0.
  logic [3:0] flen; // Frame length in bit times.
  logic clear; // Abort and go idle.
  logic take; // One-cycle pulse: frame accepted.
  logic busy; // Shifter is sending.
  logic line; // Transmitted level before inversion.
  modport ctl (output valid, frame, flen, clear, input take, busy, line);
  modport tx (input valid, frame, flen, clear, output take, busy, line);
endinterface
`default_nettype wire

// [rtl/sac_tx.sv]
// Transmit shifter that sends offered frames with no gap between them.
`timescale 1ns/1ps
`default_nettype none
module sac_tx #(
  parameter int BIT_CLKS = sac_pkg::SAC_BIT_CLKS
) (
  input wire logic pclk,
  input wire logic presetn,
  sac_tx_if.tx tx
);
  // Shifter state.
  typedef struct packed {
    logic busy;
    logic line;
    logic take;
    logic [10:0] sh;
    logic [3:0] left;
    logic [15:0] cnt;
  } sac_tx_state_t;
  localparam logic [15:0] LAST = 16'(BIT_CLKS - 1);
  sac_tx_state_t q;
  sac_tx_state_t d;

  // A new frame is taken straight at the end of the last bit, so frames run back to back.
  always_comb begin
    d = q;
    d.take = 1'b0;
    if (tx.clear) begin
      d.busy = 1'b0;
      d.line = 1'b1;
      d.cnt = '0;
      d.left = '0;
    end else if (q.busy && q.cnt != LAST) begin
      d.cnt = q.cnt + 16'h0001;
    end else if (q.busy && q.left > 4'h1) begin
      d.cnt = '0;
      d.left = q.left - 4'h1;
      d.sh = {1'b1, q.sh[10:1]};
      d.line = q.sh[1];
    end else if (tx.valid) begin
      d.busy = 1'b1;
      d.take = 1'b1;
      d.cnt = '0;
      d.sh = tx.frame;
      d.left = tx.flen;
      d.line = tx.frame[0];
    end else begin
      // Nothing queued: the line returns to idle high.
      d.busy = 1'b0;
      d.line = 1'b1;
      d.cnt = '0;
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.line <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign tx.busy = q.busy;
  assign tx.line = q.line;
  assign tx.take = q.take;

  // An idle shifter always shows the high level.
  a_tx_idle_high: assert property (@(posedge pclk) disable iff (!presetn) !q.busy |-> q.line)
    else $error("idle transmitter line not high");
endmodule
`default_nettype wire

// [rtl/sac_top.sv]
// Serial unit control registers, pin muxing, transmit sequencing and receiver.
//
// Functional notes
// - Unit on forces transmit pin to drive.
// - Unit on forces receive pin to input.
// - Loopback feeds transmitter output into receiver.
// - Unit off sets empty, done; masks transmit irq.
// - Unit enable gates unit and bit timing.
// - Polarity flip inverts every transmitted level.
// - Nine-bit mode gives 11-bit characters.
// - Parity takes most significant data position.
// - Parity select: one odd, zero even.
// - Standby exit by address mark or idle.
// - Idle counting starts after stop or start.
// - Each flag except the parity and framing errors has its own interrupt enable.
// - Transmit enable sends a preamble of ones.
// - Transmit disable finishes character, then idles high.
// - Re-enable during sending queues one idle character.
// - Receiver disable keeps receiver flags.
// - Standby mutes receiver irq; hardware clears it.
// - Break repeats while set, then one mark.
// - Break before preamble replaces the preamble.
// - Reset clears every control bit.
// - Idle flag after 10 or 11 ones.
`timescale 1ns/1ps
`default_nettype none
module sac_top #(
  parameter int BIT_CLKS = sac_pkg::SAC_BIT_CLKS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_in_pin,
  output logic serial_in_pin_out,
  output logic serial_in_pin_oe,
  output logic serial_out_pin,
  output logic serial_out_pin_oe,
  input wire logic port_e_dir_bit0,
  input wire logic port_e_dir_bit1,
  input wire logic port_e_data_bit0,
  input wire logic port_e_data_bit1,
  output logic tx_irq,
  output logic rx_irq
);
  localparam logic [15:0] LAST = 16'(BIT_CLKS - 1);
  localparam logic [15:0] HALF = 16'(BIT_CLKS / 2 - 1);

  // All state of the block except the transmit shifter, which keeps its own.
  typedef struct packed {
    logic [7:0] fmt; // Format control register.
    logic [7:0] ctl; // Interrupt and transmit/receive control register.
    logic tx_empty; // Holding register free.
    logic tx_done; // Nothing in flight.
    logic rx_full; // Received character waiting.
    logic idle; // Receive line idle.
    logic perr; // Parity error.
    logic ferr; // Framing error.
    logic [8:0] tx_hold; // Character waiting to be sent.
    logic [8:0] rx_data; // Last received character.
    logic tx_on_prev; // Transmit enable one cycle ago.
    logic pre_pend; // Preamble owed.
    logic mark_pend; // Mark bit owed after a break.
    logic valid; // Frame offered to the shifter.
    logic [10:0] frame; // Offered frame.
    logic [3:0] flen; // Offered frame length.
    sac_pkg::sac_rx_t rst; // Receiver state.
    logic [15:0] rcnt; // Receiver cycle count within a bit.
    logic [3:0] nbit; // Data bits taken so far.
    logic [3:0] ones; // Consecutive ones seen.
    logic [8:0] rsh; // Receive shift register.
    logic armed; // A character was taken since the last idle.
    logic pready; // APB ready.
    logic pslverr; // APB error.
    logic [31:0] prdata; // APB read data.
    logic out_pin; // Transmit pin level.
    logic out_oe; // Transmit pin drive enable.
    logic in_out; // Receive pin port level.
    logic in_oe; // Receive pin drive enable.
    logic tx_irq; // Transmitter request.
    logic rx_irq; // Receiver request.
  } sac_state_t;
  sac_state_t q;
  sac_state_t d;

  sac_tx_if tif ();

  // Decoded controls.
  logic unit_on;
  logic nine;
  logic tx_on;
  logic odd;
  logic tx_level;
  logic rx_line;
  logic rx_en;
  logic setup;
  logic wr;
  logic data_wr;
  logic [3:0] clen;
  logic [8:0] field9;
  logic [7:0] field8;
  logic [10:0] data_frame;
  logic [8:0] rfield;
  logic rmsb;

  assign unit_on = q.fmt[sac_pkg::SAC_F_UNIT];
  assign nine = q.fmt[sac_pkg::SAC_F_NINE];
  assign tx_on = q.ctl[sac_pkg::SAC_C_TXON];
  assign odd = q.fmt[sac_pkg::SAC_F_PODD];
  assign clen = nine ? sac_pkg::SAC_LEN_NINE : sac_pkg::SAC_LEN_EIGHT;
  assign tx_level = tif.line ^ q.fmt[sac_pkg::SAC_F_POL];
  assign rx_line = q.fmt[sac_pkg::SAC_F_LOOP] ? tx_level : serial_in_pin;
  assign rx_en = unit_on & q.ctl[sac_pkg::SAC_C_RXON];
  assign setup = psel & ~penable;
  assign wr = psel & penable & q.pready & pwrite;
  assign data_wr = wr & (paddr == sac_pkg::SAC_OFS_DATA);
  // Parity replaces the top data bit when enabled.
  assign field9 = q.fmt[sac_pkg::SAC_F_PAR] ? {^q.tx_hold[7:0] ^ odd, q.tx_hold[7:0]} : q.tx_hold;
  assign field8 = q.fmt[sac_pkg::SAC_F_PAR] ? {^q.tx_hold[6:0] ^ odd, q.tx_hold[6:0]} : q.tx_hold[7:0];
  assign data_frame = nine ? {1'b1, field9, 1'b0} : {2'b11, field8, 1'b0};
  // Eight-bit characters end one place higher in the shift register.
  assign rfield = nine ? q.rsh : {1'b0, q.rsh[8:1]};
  assign rmsb = nine ? rfield[8] : rfield[7];

  assign tif.valid = q.valid;
  assign tif.frame = q.frame;
  assign tif.flen = q.flen;
  assign tif.clear = ~unit_on;

  // Next-state logic: bus, transmit sequencing, receiver, pins.
  always_comb begin
    d = q;
    // APB: no wait state; read data is registered in the setup cycle so it comes from a flip-flop.
    d.pready = setup;
    if (setup) begin
      d.prdata = '0;
      d.pslverr = 1'b0;
      case (paddr)
        sac_pkg::SAC_OFS_FMT: begin
          d.prdata[7:0] = q.fmt;
        end
        sac_pkg::SAC_OFS_CTL: begin
          d.prdata[7:0] = q.ctl;
        end
        sac_pkg::SAC_OFS_STAT: begin
          d.prdata[5:0] = {q.ferr, q.perr, q.idle, q.rx_full, q.tx_done, q.tx_empty};
        end
        sac_pkg::SAC_OFS_DATA: begin
          d.prdata[8:0] = q.rx_data;
        end
        default: begin
          d.pslverr = 1'b1;
        end
      endcase
    end
    // Register writes at the access edge.
    if (wr) begin
      case (paddr)
        sac_pkg::SAC_OFS_FMT: begin
          d.fmt = pwdata[7:0];
        end
        sac_pkg::SAC_OFS_CTL: begin
          d.ctl = pwdata[7:0];
          // Transmit and receive enables keep their value while the unit is off.
          if (!unit_on) begin
            d.ctl[sac_pkg::SAC_C_TXON] = tx_on;
            d.ctl[sac_pkg::SAC_C_RXON] = q.ctl[sac_pkg::SAC_C_RXON];
          end
        end
        sac_pkg::SAC_OFS_STAT: begin
          // Write one to clear receiver flags; hardware sets below win.
          if (pwdata[sac_pkg::SAC_S_RXF]) d.rx_full = 1'b0;
          if (pwdata[sac_pkg::SAC_S_IDL]) d.idle = 1'b0;
          if (pwdata[sac_pkg::SAC_S_PERR]) d.perr = 1'b0;
          if (pwdata[sac_pkg::SAC_S_FERR]) d.ferr = 1'b0;
        end
        sac_pkg::SAC_OFS_DATA: begin
          d.tx_hold = pwdata[8:0];
          d.tx_empty = 1'b0;
        end
        default: begin
          d.tx_hold = q.tx_hold;
        end
      endcase
    end

    // Transmit sequencing: break, then mark, then preamble, then data.
    d.tx_on_prev = tx_on;
    if (tif.take) begin
      d.valid = 1'b0;
    end else if (!q.valid && unit_on && tx_on) begin
      if (q.ctl[sac_pkg::SAC_C_BRK]) begin
        // Breaks follow each other with no ones between; a break also eats an owed preamble.
        d.valid = 1'b1;
        d.frame = '0;
        d.flen = clen;
        d.mark_pend = 1'b1;
        d.pre_pend = 1'b0;
      end else if (q.mark_pend) begin
        // One mark bit after the last break.
        d.valid = 1'b1;
        d.frame = '1;
        d.flen = sac_pkg::SAC_LEN_MARK;
        d.mark_pend = 1'b0;
      end else if (q.pre_pend) begin
        // Preamble of ones, one character long.
        d.valid = 1'b1;
        d.frame = '1;
        d.flen = clen;
        d.pre_pend = 1'b0;
      end else if (!q.tx_empty && !data_wr && q.tx_on_prev) begin
        // Move the held character; skipped during a data write so no byte is lost.
        // It also waits out the cycle in which the enable rises, so the preamble goes first.
        d.valid = 1'b1;
        d.frame = data_frame;
        d.flen = clen;
        d.tx_empty = 1'b1;
      end
    end
    // A rising transmit enable owes a preamble, even mid-character.
    if (tx_on && !q.tx_on_prev && unit_on) d.pre_pend = 1'b1;
    d.tx_done = q.tx_empty & ~tif.busy & ~q.valid & ~q.pre_pend & ~q.mark_pend;
    // Unit off drops all queued work and reports the transmitter empty and done.
    if (!unit_on) begin
      d.valid = 1'b0;
      d.pre_pend = 1'b0;
      d.mark_pend = 1'b0;
      d.tx_empty = 1'b1;
      d.tx_done = 1'b1;
    end

    // Receiver. Disabling it stops reception but leaves the flags.
    if (!rx_en) begin
      d.rst = sac_pkg::SAC_RX_IDLE;
      d.rcnt = '0;
      d.ones = '0;
    end else begin
      d.rcnt = q.rcnt + 16'h0001;
      case (q.rst)
        sac_pkg::SAC_RX_IDLE: begin
          if (!rx_line) begin
            d.rst = sac_pkg::SAC_RX_START;
            d.rcnt = '0;
          end else if (q.rcnt == LAST) begin
            // Count idle bit times on a high line.
            d.rcnt = '0;
            if (q.ones != 4'hf) d.ones = q.ones + 4'h1;
          end
        end
        sac_pkg::SAC_RX_START: begin
          if (q.rcnt == HALF) begin
            d.rcnt = '0;
            d.nbit = '0;
            d.ones = '0;
            d.rst = rx_line ? sac_pkg::SAC_RX_IDLE : sac_pkg::SAC_RX_DATA;
          end
        end
        sac_pkg::SAC_RX_DATA: begin
          if (q.rcnt == LAST) begin
            d.rcnt = '0;
            d.rsh = {rx_line, q.rsh[8:1]};
            // Ones count from the start bit, or only after the stop bit.
            d.ones = (rx_line && !q.fmt[sac_pkg::SAC_F_ISTOP]) ? q.ones + 4'h1 : 4'h0;
            d.nbit = q.nbit + 4'h1;
            if (q.nbit == clen - 4'h3) d.rst = sac_pkg::SAC_RX_STOP;
          end
        end
        sac_pkg::SAC_RX_STOP: begin
          if (q.rcnt == LAST) begin
            d.rcnt = '0;
            d.rst = sac_pkg::SAC_RX_IDLE;
            d.ones = (rx_line && !q.fmt[sac_pkg::SAC_F_ISTOP]) ? q.ones + 4'h1 : 4'h0;
            if (q.ctl[sac_pkg::SAC_C_STBY]) begin
              // In standby only an address mark counts, and it wakes the receiver.
              if (q.fmt[sac_pkg::SAC_F_MARK] && rmsb) begin
                d.ctl[sac_pkg::SAC_C_STBY] = 1'b0;
                d.rx_full = 1'b1;
                d.rx_data = rfield;
              end
            end else begin
              d.rx_data = rfield;
              d.rx_full = 1'b1;
              d.armed = 1'b1;
              if (!rx_line) d.ferr = 1'b1;
              // Odd parity wants an odd count of ones; a mid-character change just flags.
              if (q.fmt[sac_pkg::SAC_F_PAR] && ((^rfield) != odd)) d.perr = 1'b1;
            end
          end
        end
        default: begin
          d.rst = sac_pkg::SAC_RX_IDLE;
        end
      endcase
      // Idle after a character's worth of ones.
      if (q.rst == sac_pkg::SAC_RX_IDLE && q.ones >= clen) begin
        if (q.ctl[sac_pkg::SAC_C_STBY]) begin
          // Idle wakes a standby receiver without raising the flag, but only while address-mark wake is off.
          if (!q.fmt[sac_pkg::SAC_F_MARK]) d.ctl[sac_pkg::SAC_C_STBY] = 1'b0;
        end else if (q.armed) begin
          d.idle = 1'b1;
          d.armed = 1'b0;
        end
      end
    end

    // Pins: the unit owns both pins while enabled.
    d.out_oe = unit_on | port_e_dir_bit0;
    d.out_pin = unit_on ? tx_level : port_e_data_bit0;
    d.in_oe = ~unit_on & port_e_dir_bit1;
    d.in_out = port_e_data_bit1;
    // Requests, each flag behind its own enable.
    d.tx_irq = unit_on & ((q.tx_empty & q.ctl[sac_pkg::SAC_C_TXE_EN]) |
                          (q.tx_done & q.ctl[sac_pkg::SAC_C_TXD_EN]));
    d.rx_irq = ~q.ctl[sac_pkg::SAC_C_STBY] & ((q.rx_full & q.ctl[sac_pkg::SAC_C_RXF_EN]) |
                                              (q.idle & q.ctl[sac_pkg::SAC_C_IDLE_EN]));
  end

  // State register; reset clears both control registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.fmt <= sac_pkg::SAC_FMT_RST;
      q.ctl <= sac_pkg::SAC_CTL_RST;
      q.tx_empty <= 1'b1;
      q.tx_done <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Transmit shifter.
  sac_tx #(.BIT_CLKS(BIT_CLKS)) u_tx (
    .pclk(pclk),
    .presetn(presetn),
    .tx(tif)
  );

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign serial_out_pin = q.out_pin;
  assign serial_out_pin_oe = q.out_oe;
  assign serial_in_pin_out = q.in_out;
  assign serial_in_pin_oe = q.in_oe;
  assign tx_irq = q.tx_irq;
  assign rx_irq = q.rx_irq;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A rising transmit enable with no frame offered and no break or mark owed.
  sequence s_tx_rise;
    tx_on && !q.tx_on_prev && unit_on && !q.ctl[sac_pkg::SAC_C_BRK] && !q.valid && !q.mark_pend;
  endsequence
  // The preamble frame offered two cycles later.
  sequence s_preamble;
    q.valid && (q.frame == 11'h7ff) && (q.flen == clen);
  endsequence

  a_out_drive: assert property (unit_on |=> serial_out_pin_oe)
    else $error("transmit pin not driven");
  a_in_release: assert property (unit_on |=> !serial_in_pin_oe)
    else $error("receive pin driven");
  a_loop_route: assert property (rx_en && q.fmt[sac_pkg::SAC_F_LOOP] && q.rst == sac_pkg::SAC_RX_IDLE
    && !tx_level |=> q.rst == sac_pkg::SAC_RX_START)
    else $error("loopback start missed");
  a_off_flags: assert property ($fell(unit_on) |=> q.tx_empty && q.tx_done && !tx_irq)
    else $error("unit off flags wrong");
  a_invert_idle: assert property (unit_on && q.fmt[sac_pkg::SAC_F_POL] && !tif.busy |=> !serial_out_pin)
    else $error("idle level not inverted");
  a_preamble_start: assert property (s_tx_rise |-> ##2 s_preamble)
    else $error("preamble not offered");
  a_break_frame: assert property ($rose(q.valid) && $past(q.ctl[sac_pkg::SAC_C_BRK]) |-> q.frame == 11'h000)
    else $error("break frame not all zero");
  a_standby_mute: assert property (q.ctl[sac_pkg::SAC_C_STBY] |=> !rx_irq)
    else $error("receiver request in standby");
  a_irq_gate: assert property (!q.ctl[sac_pkg::SAC_C_TXE_EN] && !q.ctl[sac_pkg::SAC_C_TXD_EN] |=> !tx_irq)
    else $error("transmit request not gated");
endmodule
`default_nettype wire

// [test/sac_peer.sv]
// Remote serial transceiver model that sends and receives framed characters.
`timescale 1ns/1ps
`default_nettype none
module sac_peer #(
  parameter int B = 4
) (
  input wire logic clk,
  input wire logic line_i,
  input wire logic nine,
  input wire logic listen,
  output logic line_o,
  output logic got_v,
  output logic [9:0] got
);
  // The line idles at the high level between frames.
  initial begin
    line_o = 1'b1;
    got_v = 1'b0;
    got = '0;
  end
  // Sends start, data field and stop bit, first bit first, one bit time each.
  task automatic send(input logic [9:0] f);
    line_o <= 1'b0;
    repeat (B) @(posedge clk);
    for (int i = 0; i < (nine ? 10 : 9); i++) begin
      line_o <= f[i];
      repeat (B) @(posedge clk);
    end
  endtask
  // Catches a start edge, checks it at mid bit, then samples each bit centre.
  always begin
    @(negedge line_i iff listen);
    repeat (B / 2) @(posedge clk);
    if (line_i === 1'b0) begin
      got = '0;
      for (int i = 0; i < (nine ? 10 : 9); i++) begin
        repeat (B) @(posedge clk);
        got[i] = line_i;
      end
      got_v <= 1'b1;
      @(posedge clk);
      got_v <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [test/tb_sac_top.sv]
// Self-checking testbench for the serial control block.
`timescale 1ns/1ps
`default_nettype none
module tb_sac_top;
  localparam int B = 4;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0, lf = 8'd87;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, si_out, si_oe, so, so_oe, tx_irq, rx_irq, got_v, peer_line;
  logic d0 = 0, d1 = 0, e0 = 0, e1 = 0, listen = 1, nine = 0;
  logic [9:0] got;
  logic [32:0] rdq[$], rmq[$];
  logic [9:0] chq[$];
  int n_errors = 0, checks = 0;
  // Pin levels: a released transmit pin is pulled up; a released receive pin follows the peer.
  wire logic tx_wire = so_oe ? so : 1'b1;
  wire logic rx_wire = si_oe ? si_out : peer_line;
  sac_top #(.BIT_CLKS(B)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_in_pin(rx_wire), .serial_in_pin_out(si_out), .serial_in_pin_oe(si_oe),
    .serial_out_pin(so), .serial_out_pin_oe(so_oe), .port_e_dir_bit0(e0), .port_e_dir_bit1(e1),
    .port_e_data_bit0(d0), .port_e_data_bit1(d1), .tx_irq(tx_irq), .rx_irq(rx_irq));
  sac_peer #(.B(B)) peer_u (.clk(pclk), .line_i(tx_wire), .nine(nine), .listen(listen),
    .line_o(peer_line), .got_v(got_v), .got(got));
  initial forever #2.5 pclk = ~pclk;
  // Pseudo-random byte source.
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic end_of_test;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Masked comparison that counts and reports.
  task automatic chk(input logic [32:0] g, input logic [32:0] e, input logic [32:0] m);
    checks++;
    if ((g & m) !== (e & m)) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_errors++;
      end_of_test();
    end else begin
      psel <= 1'b0; penable <= 1'b0;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // Notes the expected error flag and data, then reads.
  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
    rdq.push_back(e);
    rmq.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask
  // Waits a bounded time for every noted result to arrive.
  task automatic waitq;
    int n;
    n = 0;
    while ((rdq.size() != 0 || chq.size() != 0) && n < 3000) begin @(posedge pclk); n++; end
    if (n >= 3000) begin
      n_errors++;
      end_of_test();
    end
  endtask
  // Compares each read answer and each received frame with the oldest note.
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (rdq.size() == 0) chk(33'h0, 33'h1, 33'h1);
      else chk({pslverr, prdata}, rdq.pop_front(), rmq.pop_front());
    end
    if (got_v === 1'b1) begin
      if (chq.size() == 0) chk(33'h0, 33'h1, 33'h1);
      else chk({23'h0, got}, {23'h0, chq.pop_front()}, '1);
    end
  end
  logic [7:0] fm [4] = '{8'h40, 8'h42, 8'h43, 8'h50};
  logic [7:0] r;
  logic [9:0] ex;
  int n;
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, 33'h0, '1);
    rd(8'h04, 33'h0, '1);
    rd(8'h08, 33'h3, 33'h3);
    rd(8'h10, 33'h1_0000_0000, '1);
    wr(8'h04, 32'h0c);
    rd(8'h04, 33'h0, 33'hc);
    e0 <= 1'b0; e1 <= 1'b1; d1 <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({31'h0, si_out, so_oe, si_oe}, 33'h5, '1);
    wr(8'h00, 32'h40);
    repeat (3) @(posedge pclk);
    chk({32'h0, so_oe, si_oe}, 33'h2, '1);
    wr(8'h04, 32'h88);
    repeat (3) @(posedge pclk);
    chk({32'h0, tx_irq}, 33'h1, '1);
    for (int i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      r = lf;
      case (i)
        0: ex = {2'b01, r};
        3: ex = {1'b1, r[0], r};
        default: ex = {2'b01, ^r[6:0] ^ fm[i][0], r[6:0]};
      endcase
      wr(8'h00, {24'h0, fm[i]});
      nine <= fm[i][4];
      chq.push_back(ex);
      wr(8'h0c, {23'h0, (i == 3) ? r[0] : 1'b0, r});
      waitq();
    end
    wr(8'h04, 32'h89);
    n = 0;
    while (tx_wire !== 1'b0 && n < 500) begin @(posedge pclk); n++; end
    chk({32'h0, tx_wire}, 33'h0, '1);
    wr(8'h04, 32'h88);
    chq.push_back(10'h0);
    waitq();
    // A second break may already be queued while the control bit was still set.
    n = 0;
    while (tx_wire !== 1'b1 && n < 500) begin @(posedge pclk); n++; end
    chk({32'h0, tx_wire}, 33'h1, '1);
    listen <= 1'b0;
    wr(8'h00, 32'h70);
    repeat (4) @(posedge pclk);
    chk({32'h0, tx_wire}, 33'h0, '1);
    wr(8'h00, 32'h48);
    nine <= 1'b0;
    repeat (4) @(posedge pclk);
    listen <= 1'b1;
    wr(8'h04, 32'h24);
    lf = lfsr(lf);
    r = lf;
    peer_u.send({2'b01, r});
    repeat (3) @(posedge pclk);
    chk({32'h0, rx_irq}, 33'h1, '1);
    rd(8'h0c, {25'h0, r}, 33'h1ff);
    wr(8'h04, 32'h26);
    repeat (3) @(posedge pclk);
    chk({32'h0, rx_irq}, 33'h0, '1);
    peer_u.send({2'b01, 8'h80 | r});
    repeat (3) @(posedge pclk);
    rd(8'h04, 33'h24, 33'hff);
    wr(8'h04, 32'h20);
    rd(8'h08, 33'h4, 33'h4);
    wr(8'h08, 32'h3c);
    wr(8'h00, 32'hc0);
    wr(8'h04, 32'h0c);
    peer_u.line_o <= 1'b0;
    lf = lfsr(lf);
    r = lf;
    chq.push_back({2'b01, r});
    wr(8'h0c, {24'h0, r});
    repeat (22 * B + 20) @(posedge pclk);
    rd(8'h0c, {25'h0, r}, 33'h1ff);
    waitq();
    peer_u.line_o <= 1'b1;
    wr(8'h04, 32'h80);
    wr(8'h00, 32'h00);
    repeat (3) @(posedge pclk);
    chk({32'h0, tx_irq}, 33'h0, '1);
    rd(8'h08, 33'h3, 33'h3);
    waitq();
    end_of_test();
  end
endmodule
`default_nettype wire
